// *** logic/ebr_eeprom_front.sv ***
`timescale 1ns/1ps
`include "ebr_map.svh"

// Contract
// (R1) a stop ending a write while supply is low cancels the write.
// (R2) there is no reset pin; only start then stop brings the engine idle. The engine also idles on a stop alone.
// (R3) a master reset alone leaves the engine state untouched.
// (R4) the master waits while the device holds data low.
// (R5) the master resyncs with start, nine clocks data high, start, stop.
// (R6) dummy clocks with data high end any output; a start resets state.
// (R7) after the dummy clocks the master must send a start at once.
// (R8) the master should resync once at system start.
// (R9) the master should check every acknowledge.
// (R10) power-on clear initialises the engine, which then enters standby.
// (R11) instructions are ignored during the initialisation interval.
// (R12) after a bad supply ramp the master resyncs before use.
// (R13) data is only pulled low or released, never driven high.
// (R14) during a write cycle all bus traffic is ignored and never acked.
// (R15) a stop after write data bytes starts the write cycle.
// (R16) start is data falling with clock high; stop is data rising.
module ebr_eeprom_front #(
	parameter int INIT_WAIT_NS  = `EBR_INIT_WAIT_NS,
	parameter int WRITE_TIME_NS = `EBR_WRITE_TIME_NS
) (
	input  wire logic       core_clk,
	input  wire logic       rst_b,
	input  wire logic       scl_in,
	input  wire logic       sda_in,
	output logic            sda_out,
	output logic            sda_oe,
	input  wire logic       low_supply,
	input  wire logic [7:0] rd_byte,
	output logic            rd_next,
	output logic [7:0]      wr_byte,
	output logic            wr_byte_vld,
	output logic            wr_commit,
	output logic            wr_cancel,
	output logic            standby,
	output logic            busy
);

	localparam int INIT_CYC  = `EBR_NS_TO_CYC(INIT_WAIT_NS);
	localparam int WRITE_CYC = `EBR_NS_TO_CYC(WRITE_TIME_NS);

	ebr_cond_if cond ();

	ebr_pkg::ebr_state_t state_r;
	logic [23:0]         timer_r;
	logic [3:0]          bit_cnt_r;
	logic [7:0]          rx_r;
	logic [7:0]          tx_r;
	logic                addr_hit_r;
	logic                rw_r;
	logic                mack_r;
	logic                sda_low_r;
	logic [7:0]          wr_cnt_r;
	logic                listen;
	logic                ev_start;
	logic                ev_stop;
	logic                in_byte;
	logic                fall8;
	logic                fall9;
	logic                hit_now;
	logic                commit_ok;
	logic                go_rd;
	logic                rd_more;

	ebr_line_watch u_watch (
		.core_clk       (core_clk),
		.rst_b          (rst_b),
		.scl_pin        (scl_in),
		.sda_pin        (sda_in),
		.low_supply_pin (low_supply),
		.cond           (cond)
	);

	////////////////////////////////////////////////////////////////////////
	// (R11) deaf while initialising
	// (R14) deaf while writing
	assign listen   = (state_r != ebr_pkg::EBR_S_INIT) &&
		(state_r != ebr_pkg::EBR_S_BUSY);
	assign ev_start = cond.start & listen;
	assign ev_stop  = cond.stop & listen;
	assign in_byte  = (state_r == ebr_pkg::EBR_S_ADDR) ||
		(state_r == ebr_pkg::EBR_S_WR) || (state_r == ebr_pkg::EBR_S_RD);
	assign fall8    = cond.scl_fall && (bit_cnt_r == `EBR_ACK_SLOT);
	assign fall9    = cond.scl_fall && (bit_cnt_r == `EBR_BYTE_END);
	assign hit_now  = (rx_r[7:1] == `EBR_DEV_ADDR);
	assign go_rd    = (state_r == ebr_pkg::EBR_S_ADDR) && addr_hit_r && rw_r;
	assign rd_more  = (state_r == ebr_pkg::EBR_S_RD) && mack_r;
	// a stop after a whole byte has seen exactly the one clock rise that
	// carries it; a stop mid-byte just ends the transfer
	assign commit_ok = (state_r == ebr_pkg::EBR_S_WR) &&
		(wr_cnt_r != 8'h00) && (bit_cnt_r == 4'h1);

	////////////////////////////////////////////////////////////////////////
	// (R2) no reset pin: rst_b is power-on clear only
	// (R3) master reset alone changes nothing
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			// (R10) power-on clear
			state_r <= ebr_pkg::EBR_S_INIT;
		end else if (!listen) begin
			// (R10) standby after init
			if (timer_r == 24'h000000)
				state_r <= ebr_pkg::EBR_S_IDLE;
		end else if (ev_start) begin
			// (R6) start resets protocol
			state_r <= ebr_pkg::EBR_S_ADDR;
		end else if (ev_stop) begin
			// (R15) stop commits write
			if (commit_ok && !cond.low_supply)
				state_r <= ebr_pkg::EBR_S_BUSY;
			else
				state_r <= ebr_pkg::EBR_S_IDLE;
		end else if (fall9) begin
			case (state_r)
			ebr_pkg::EBR_S_ADDR: begin
				if (!addr_hit_r)
					state_r <= ebr_pkg::EBR_S_WAIT;
				else if (rw_r)
					state_r <= ebr_pkg::EBR_S_RD;
				else
					state_r <= ebr_pkg::EBR_S_WR;
			end
			// (R6) no master ack ends output
			ebr_pkg::EBR_S_RD: begin
				if (!mack_r)
					state_r <= ebr_pkg::EBR_S_WAIT;
			end
			default: state_r <= state_r;
			endcase
		end
	end

	// init and write-cycle timer
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b)
			timer_r <= 24'(INIT_CYC);
		else if (ev_stop && commit_ok && !cond.low_supply)
			timer_r <= 24'(WRITE_CYC);
		else if (timer_r != 24'h000000)
			timer_r <= timer_r - 24'h000001;
	end

	////////////////////////////////////////////////////////////////////////
	// bit slot counter and receive shifter
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			bit_cnt_r <= 4'h0;
			rx_r      <= 8'h00;
		end else if (ev_start || ev_stop || !in_byte || fall9) begin
			bit_cnt_r <= 4'h0;
		end else if (cond.scl_rise) begin
			bit_cnt_r <= bit_cnt_r + 4'h1;
			if (bit_cnt_r < `EBR_ACK_SLOT)
				rx_r <= {rx_r[6:0], cond.sda};
		end
	end

	// address decode and master acknowledge capture
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			addr_hit_r <= 1'b0;
			rw_r       <= 1'b0;
			mack_r     <= 1'b0;
		end else begin
			if (fall8 && state_r == ebr_pkg::EBR_S_ADDR) begin
				addr_hit_r <= hit_now;
				rw_r       <= rx_r[0];
			end
			// (R9) ack low means send more
			if (cond.scl_rise && bit_cnt_r == `EBR_ACK_SLOT &&
				state_r == ebr_pkg::EBR_S_RD)
				mack_r <= ~cond.sda;
		end
	end

	// transmit shifter; rd_byte must be stable at the load edge
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b)
			tx_r <= 8'h00;
		else if (fall9 && (go_rd || rd_more))
			tx_r <= rd_byte;
		else if (cond.scl_fall && state_r == ebr_pkg::EBR_S_RD &&
			bit_cnt_r != 4'h0 && bit_cnt_r < `EBR_ACK_SLOT)
			tx_r <= {tx_r[6:0], 1'b1};
	end

	////////////////////////////////////////////////////////////////////////
	// sda pull-down; pulled low only on scl fall so start/stop stay clean
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			sda_low_r <= 1'b0;
		// (R6) start or stop drops output
		end else if (ev_start || ev_stop || !in_byte) begin
			sda_low_r <= 1'b0;
		end else if (fall9) begin
			// (R6) ack released after ninth clock
			sda_low_r <= (go_rd || rd_more) ? ~rd_byte[7] : 1'b0;
		end else if (fall8) begin
			// (R14) ack only when listening
			if (state_r == ebr_pkg::EBR_S_ADDR)
				sda_low_r <= hit_now;
			else
				sda_low_r <= (state_r == ebr_pkg::EBR_S_WR);
		end else if (cond.scl_fall && state_r == ebr_pkg::EBR_S_RD &&
			bit_cnt_r != 4'h0) begin
			sda_low_r <= ~tx_r[6];
		end
	end

	// (R13) open drain: drive low or release
	assign sda_out = 1'b0;
	assign sda_oe  = sda_low_r;

	////////////////////////////////////////////////////////////////////////
	// user-side write stream and cycle control
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			wr_byte     <= 8'h00;
			wr_byte_vld <= 1'b0;
			wr_commit   <= 1'b0;
			wr_cancel   <= 1'b0;
			rd_next     <= 1'b0;
			wr_cnt_r    <= 8'h00;
		end else begin
			wr_byte_vld <= 1'b0;
			// (R15) start write cycle
			wr_commit   <= ev_stop && commit_ok && !cond.low_supply;
			// (R1) low supply cancels
			wr_cancel   <= ev_stop && commit_ok && cond.low_supply;
			rd_next     <= fall9 && (go_rd || rd_more);
			if (ev_start || ev_stop) begin
				wr_cnt_r <= 8'h00;
			end else if (fall8 && state_r == ebr_pkg::EBR_S_WR) begin
				wr_byte     <= rx_r;
				wr_byte_vld <= 1'b1;
				if (wr_cnt_r != 8'hFF)
					wr_cnt_r <= wr_cnt_r + 8'h01;
			end
		end
	end

	assign standby = (state_r == ebr_pkg::EBR_S_IDLE);
	assign busy    = (state_r == ebr_pkg::EBR_S_BUSY);

endmodule // ebr_eeprom_front

// *** logic/ebr_line_watch.sv ***
`timescale 1ns/1ps
`include "ebr_map.svh"

module ebr_line_watch (
	input  wire logic   core_clk,
	input  wire logic   rst_b,
	input  wire logic   scl_pin,
	input  wire logic   sda_pin,
	input  wire logic   low_supply_pin,
	ebr_cond_if.watch   cond
);

	logic [2:0] raw;
	logic [2:0] ff1_r;
	logic [2:0] ff2_r;
	logic [2:0] ff3_r;
	logic [2:0] agree;
	logic [2:0] lvl_r;
	logic [2:0] lvl_d_r;

	assign raw   = {low_supply_pin, sda_pin, scl_pin};
	assign agree = ~(ff2_r ^ ff3_r);

	////////////////////////////////////////////////////////////////////////
	// three-stage sync; ff1 feeds only ff2
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			ff1_r <= `EBR_LINE_IDLE;
			ff2_r <= `EBR_LINE_IDLE;
			ff3_r <= `EBR_LINE_IDLE;
		end else begin
			ff1_r <= raw;
			ff2_r <= ff1_r;
			ff3_r <= ff2_r;
		end
	end

	// level moves only when stages two and three agree (glitch filter)
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			lvl_r   <= `EBR_LINE_IDLE;
			lvl_d_r <= `EBR_LINE_IDLE;
		end else begin
			lvl_r   <= (ff3_r & agree) | (lvl_r & ~agree);
			lvl_d_r <= lvl_r;
		end
	end

	////////////////////////////////////////////////////////////////////////
	assign cond.scl        = lvl_r[0];
	assign cond.sda        = lvl_r[1];
	assign cond.low_supply = lvl_r[2];
	assign cond.scl_rise   = lvl_r[0] & ~lvl_d_r[0];
	assign cond.scl_fall   = ~lvl_r[0] & lvl_d_r[0];
	// (R16) start and stop
	assign cond.start = lvl_r[0] & lvl_d_r[0] & lvl_d_r[1] & ~lvl_r[1];
	assign cond.stop  = lvl_r[0] & lvl_d_r[0] & ~lvl_d_r[1] & lvl_r[1];

endmodule // ebr_line_watch

// *** shared/ebr_cond_if.sv ***
`timescale 1ns/1ps

interface ebr_cond_if;
	logic scl;
	logic sda;
	logic low_supply;
	logic scl_rise;
	logic scl_fall;
	logic start;
	logic stop;

	modport watch (output scl, sda, low_supply, scl_rise, scl_fall,
		start, stop);
	modport engine (input scl, sda, low_supply, scl_rise, scl_fall,
		start, stop);
endinterface // ebr_cond_if

// *** shared/ebr_map.svh ***
`ifndef EBR_MAP_SVH
`define EBR_MAP_SVH

// core clock period in picoseconds (200 MHz)
`define EBR_CLK_PERIOD_PS      5000
// power-on initialisation interval, nanoseconds
`define EBR_INIT_WAIT_NS       1000
// internal nonvolatile write cycle, nanoseconds
`define EBR_WRITE_TIME_NS      1000
// least times round up to whole cycles
`define EBR_NS_TO_CYC(ns) \
	(((ns) * 1000 + `EBR_CLK_PERIOD_PS - 1) / `EBR_CLK_PERIOD_PS)
// bit positions inside a byte slot
`define EBR_ACK_SLOT           4'h8
`define EBR_BYTE_END           4'h9
// 7-bit slave address, arbitrary default
`define EBR_DEV_ADDR           7'h50
// filtered line levels after reset: scl, sda high, low supply off
`define EBR_LINE_IDLE          3'h3

`endif

// *** shared/ebr_pkg.sv ***
package ebr_pkg;

	typedef enum logic [2:0] {
		EBR_S_INIT = 3'b000,
		EBR_S_IDLE = 3'b001,
		EBR_S_ADDR = 3'b010,
		EBR_S_WR   = 3'b011,
		EBR_S_RD   = 3'b100,
		EBR_S_WAIT = 3'b101,
		EBR_S_BUSY = 3'b110
	} ebr_state_t;

endpackage

// *** tb/ebr_front_checker.sv ***
`timescale 1ns/1ps

module ebr_front_checker #(
	parameter int INIT_WAIT_NS  = 1000,
	parameter int WRITE_TIME_NS = 1000
) (
	input wire logic       core_clk,
	input wire logic       rst_b,
	input wire logic       scl_in,
	input wire logic       sda_in,
	input wire logic       sda_out,
	input wire logic       sda_oe,
	input wire logic       low_supply,
	input wire logic [7:0] rd_byte,
	input wire logic       rd_next,
	input wire logic [7:0] wr_byte,
	input wire logic       wr_byte_vld,
	input wire logic       wr_commit,
	input wire logic       wr_cancel,
	input wire logic       standby,
	input wire logic       busy
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	////////////////////////////////////////////////////////////////////
	property p_od; sda_out == 1'h0; endproperty
	a_od: assert property (p_od)
		else $error("sda driven high");
	property p_busy_quiet; busy |-> !sda_oe; endproperty
	a_busy_quiet: assert property (p_busy_quiet)
		else $error("ack in write");
	property p_idle_quiet; standby |-> !sda_oe && !busy; endproperty
	a_idle_quiet: assert property (p_idle_quiet)
		else $error("idle drives");
	property p_init_std; $rose(rst_b) |-> !standby [*8]; endproperty
	a_init_std: assert property (p_init_std)
		else $error("early standby");
	property p_init_quiet; $rose(rst_b) |-> !sda_oe [*8]; endproperty
	a_init_quiet: assert property (p_init_quiet)
		else $error("init ack");
	property p_commit; wr_commit |=> busy [*8]; endproperty
	a_commit: assert property (p_commit)
		else $error("no write cycle");
	property p_busy_end; $rose(busy) |-> ##[1:1000] standby; endproperty
	a_busy_end: assert property (p_busy_end)
		else $error("write hangs");
	property p_cancel; wr_cancel |-> !wr_commit ##1 !busy [*2]; endproperty
	a_cancel: assert property (p_cancel)
		else $error("cancel wrote");
endmodule // ebr_front_checker

bind ebr_eeprom_front ebr_front_checker #(.INIT_WAIT_NS(INIT_WAIT_NS),
	.WRITE_TIME_NS(WRITE_TIME_NS)) u_chk (.core_clk(core_clk),
	.rst_b(rst_b), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
	.sda_oe(sda_oe), .low_supply(low_supply), .rd_byte(rd_byte),
	.rd_next(rd_next), .wr_byte(wr_byte), .wr_byte_vld(wr_byte_vld),
	.wr_commit(wr_commit), .wr_cancel(wr_cancel), .standby(standby),
	.busy(busy));

// *** tb/ebr_master_model.sv ***
`timescale 1ns/1ps

module ebr_master_model (
	output logic     scl,
	output logic     sda_drv,
	input wire logic sda_line
);
	// clock stands high between frames, 64 ns per bit
	initial begin
		scl = 1'h1;
		sda_drv = 1'h1;
	end
	////////////////////////////////////////////////////////////////////
	// start shape
	// pins move by non-blocking assignment so a step that lands on a
	// core clock edge cannot race the synchroniser's first stage
	task automatic start();
		#16 sda_drv <= 1'h1;
		#16 scl <= 1'h1;
		#16 sda_drv <= 1'h0;
		#16 scl <= 1'h0;
	endtask
	task automatic stop();
		#16 sda_drv <= 1'h0;
		#16 scl <= 1'h1;
		#16 sda_drv <= 1'h1;
	endtask
	// late sample: the filtered answer lags the pin by several cycles
	task automatic clk_bit(input logic b, output logic r);
		#16 sda_drv <= b;
		#16 scl <= 1'h1;
		#28 r = sda_line;
		#4 scl <= 1'h0;
	endtask
	task automatic send(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) clk_bit(d[i], r);
		clk_bit(1'h1, r);
		ack = ~r;
	endtask
	// start, nine clocks data high, start at once, stop
	task automatic resync();
		logic r;
		start();
		repeat (9) clk_bit(1'h1, r);
		start();
		stop();
	endtask
	// master reset: lines let go, data first so no stop is made
	task automatic drop();
		#16 sda_drv <= 1'h1;
		#16 scl <= 1'h1;
	endtask
endmodule // ebr_master_model

// *** tb/tb_top.sv ***
`timescale 1ns/1ps

module tb_top;
	logic       core_clk   = 1'h0;
	logic       rst_b      = 1'h0;
	logic       low_supply = 1'h0;
	logic [7:0] rd_byte    = 8'h00;
	logic       scl_m, sda_m, sda_w, sda_out, sda_oe, rd_next, ack;
	logic       wr_byte_vld, wr_commit, wr_cancel, standby, busy;
	logic [7:0] wr_byte;
	int         mismatches = 0;
	int         n_checks   = 0;
	int         n_commit   = 0;
	int         n_cancel   = 0;
	int         n_vld      = 0;
	int         n_rdn      = 0;
	int         cb, xb, vb, rb;

	always #2.5 core_clk = ~core_clk;
	// open drain with pull-up
	assign sda_w = sda_m & ~sda_oe;
	always @(posedge core_clk) begin
		n_commit += int'(wr_commit === 1'h1);
		n_cancel += int'(wr_cancel === 1'h1);
		n_vld    += int'(wr_byte_vld === 1'h1);
		n_rdn    += int'(rd_next === 1'h1);
	end
	ebr_eeprom_front #(.INIT_WAIT_NS(100), .WRITE_TIME_NS(1000)) uut (
		.core_clk(core_clk), .rst_b(rst_b), .scl_in(scl_m), .sda_in(sda_w),
		.sda_out(sda_out), .sda_oe(sda_oe), .low_supply(low_supply),
		.rd_byte(rd_byte), .rd_next(rd_next), .wr_byte(wr_byte),
		.wr_byte_vld(wr_byte_vld), .wr_commit(wr_commit),
		.wr_cancel(wr_cancel), .standby(standby), .busy(busy));
	ebr_master_model m (.scl(scl_m), .sda_drv(sda_m), .sda_line(sda_w));
	////////////////////////////////////////////////////////////////////
	task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("FAIL %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic wait_idle();
		for (int i = 0; i < 2000; i++) begin
			@(posedge core_clk);
			if (standby === 1'h1) return;
		end
		chk("standby wait", 8'h01, 8'h00);
		tally_and_finish();
	endtask
	////////////////////////////////////////////////////////////////////
	// address sent too early on purpose
	task automatic t_init();
		m.start();
		m.send(8'hA0, ack);
		chk("init ack", 8'h00, {7'h00, ack});
		m.stop();
		wait_idle();
		chk("standby", 8'h01, {7'h00, standby});
		m.resync();
		$display("test init done");
	endtask
	task automatic t_write();
		cb = n_commit;
		vb = n_vld;
		m.start();
		m.send(8'hA0, ack);
		chk("addr ack", 8'h01, {7'h00, ack});
		m.send(8'h5A, ack);
		chk("wr_byte", 8'h5A, wr_byte);
		chk("wr_byte_vld", 8'h01, 8'(n_vld - vb));
		m.stop();
		m.start();
		m.send(8'hA0, ack);
		chk("busy ack", 8'h00, {7'h00, ack});
		chk("commit", 8'h01, 8'(n_commit - cb));
		m.stop();
		wait_idle();
		$display("test write done");
	endtask
	task automatic t_cancel();
		cb = n_commit;
		xb = n_cancel;
		@(posedge core_clk) low_supply <= 1'h1;
		m.start();
		m.send(8'hA0, ack);
		m.send(8'h33, ack);
		m.stop();
		wait_idle();
		repeat (2) @(posedge core_clk);
		chk("cancel", 8'h01, 8'(n_cancel - xb));
		chk("no commit", 8'h00, 8'(n_commit - cb));
		@(posedge core_clk) low_supply <= 1'h0;
		$display("test cancel done");
	endtask
	// device holds data low during a read of zeros
	task automatic t_resync();
		cb = n_commit;
		rb = n_rdn;
		m.start();
		m.send(8'hA1, ack);
		chk("read ack", 8'h01, {7'h00, ack});
		m.resync();
		wait_idle();
		chk("no commit", 8'h00, 8'(n_commit - cb));
		chk("rd_next", 8'h01, 8'(n_rdn - rb));
		m.start();
		m.send(8'hA0, ack);
		chk("ack after resync", 8'h01, {7'h00, ack});
		m.stop();
		wait_idle();
		$display("test resync done");
	endtask
	task automatic t_mreset();
		cb = n_commit;
		m.start();
		m.send(8'hA0, ack);
		m.clk_bit(1'h1, ack);
		m.drop();
		repeat (50) @(posedge core_clk);
		chk("state kept", 8'h00, {7'h00, standby});
		m.start();
		m.stop();
		wait_idle();
		chk("idle", 8'h01, {7'h00, standby});
		chk("no commit", 8'h00, 8'(n_commit - cb));
		$display("test master reset done");
	endtask
	initial begin
		repeat (6) @(posedge core_clk);
		rst_b <= 1'h1;
		t_init();
		t_write();
		t_cancel();
		t_resync();
		t_mreset();
		tally_and_finish();
	end
endmodule // tb_top
